// ---- hw/mcr_regs.sv ----
/*
  Extended-resolution LSB register and pin/tach configuration register
  three, with the pin routing, max_cooling_on_thermal, tach rate and freeze behaviour they steer.
  Assumes a register port from the serial management front end on ref_clk,
  measurement results and high-byte read strobes from the monitor core on
  ref_clk, and active-low thermal pins arriving asynchronously.
*/
// Notes on behaviour
// - Bits 1:0 of the LSB register read the low two bits of the 12 V reading.
// - Bits 3:2 read the low two bits of the first remote temperature reading.
// - Bits 5:4 read the low two bits of the on-chip temperature reading.
// - Bits 7:6 read the low two bits of the second remote temperature reading.
// - Reading the LSB register freezes it and each high byte until that high byte is read.
// - Config bit 0 set makes the shared pin an SMBALERT output, clear makes it fan drive two.
// - Config bit 1 enables the thermal signal on pin 22 unless the pin-function field selects thermal; the pin-function field routes the shared pin.
// - An asserted thermal signal may be set up to start a timer on its duration.
// - With max_cooling_on_thermal set and the thermal signal an input, its assertion runs all fans at maximum.
// - Fast set takes tach readings every 250 ms instead of once per second.
// - Bits 4 to 7 enable continuous tach measurement on channels one to four.
// - A channel with continuous measurement gets no pulse stretching.
// - Config register three is read-only while the lock bit is set.
`include "mcr_defines.svh"

module mcr_regs #(
  parameter int unsigned TACH_SLOW_CYC = `MCR_TACH_SLOW_CYC,
  parameter int unsigned TACH_FAST_CYC = `MCR_TACH_FAST_CYC
) (
  // Clock, reset, enable
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic               ce,
  // Register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  // Settings held elsewhere
  input  wire logic               cfg_lock,
  input  wire logic [1:0]         shared_pin_function,
  input  wire logic               thermal_is_input,
  input  wire logic               thermal_timer_en,
  // Measurements
  input  wire logic               meas_valid,
  input  wire logic [9:0]         v12_meas,
  input  wire logic [9:0]         remote_one_meas,
  input  wire logic [9:0]         onchip_meas,
  input  wire logic [9:0]         remote_two_meas,
  input  wire logic [3:0]         high_byte_rd,
  output logic      [3:0]         high_byte_freeze,
  // Thermal pins, active low
  input  wire logic               pin22_n,
  input  wire logic               pin14_n,
  output logic                    pin22_thermal_mode,
  output mcr_pkg::mcr_pin_fn_t    pin14_role,
  output logic                    thermal_asserted,
  output logic                    thermal_timer_start,
  // Shared alert / fan drive two pin
  input  wire logic               smbalert_req,
  input  wire logic               fan_drive_two_output,
  output logic                    pin10_o,
  output logic                    pin10_oe,
  // Fan control
  output logic                    max_cooling_on_thermal,
  output logic                    tach_measure,
  output logic      [3:0]         continuous_tach,
  output logic      [3:0]         pulse_stretch_en
);

  // Register state
  logic [7:0] ext_r,    ext_nxt;
  logic [7:0] cfg3_r,   cfg3_nxt;
  logic [3:0] frz_r,    frz_nxt;
  logic [7:0] rdata_r,  rdata_nxt;
  logic       rd_ext;
  logic       wr_cfg3;
  logic [7:0] fresh;

  assign rd_ext  = reg_rd && reg_addr == `MCR_ADDR_EXT_LSBS;
  assign wr_cfg3 = reg_wr && reg_addr == `MCR_ADDR_CFG3;
  assign fresh   = {remote_two_meas[1:0], onchip_meas[1:0],
                    remote_one_meas[1:0], v12_meas[1:0]};

  always_comb begin
    ext_nxt   = ext_r;
    cfg3_nxt  = cfg3_r;
    frz_nxt   = frz_r;
    rdata_nxt = rdata_r;
    if (ce) begin
      // Only channels without a freeze take new low bits
      for (int i = 0; i < 4; i++) begin
        if (meas_valid && !frz_r[i]) begin
          ext_nxt[2*i +: 2] = fresh[2*i +: 2];
        end
      end
      // Reading the LSBs freezes all; a high-byte read releases its channel
      for (int i = 0; i < 4; i++) begin
        if (rd_ext) begin
          frz_nxt[i] = 1'b1;
        end else if (high_byte_rd[i]) begin
          frz_nxt[i] = 1'b0;
        end
      end
      // Writes to the LSB register fall through untouched
      if (wr_cfg3 && !cfg_lock) begin
        cfg3_nxt = reg_wdata;
      end
      if (reg_rd) begin
        case (reg_addr)
          `MCR_ADDR_EXT_LSBS: rdata_nxt = ext_r;
          `MCR_ADDR_CFG3:     rdata_nxt = cfg3_r;
          default:            rdata_nxt = `MCR_RDATA_UNMAPPED;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ext_r   <= `MCR_EXT_RESET;
      cfg3_r  <= `MCR_CFG3_RESET;
      frz_r   <= 4'h0;
      rdata_r <= 8'h00;
    end else begin
      ext_r   <= ext_nxt;
      cfg3_r  <= cfg3_nxt;
      frz_r   <= frz_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata        = rdata_r;
  assign high_byte_freeze = frz_r;

  // Pin synchronisers: stage one feeds stage two only
  logic [1:0] pin_s1_r, pin_s1_nxt;
  logic [1:0] pin_s2_r, pin_s2_nxt;

  always_comb begin
    pin_s1_nxt = pin_s1_r;
    pin_s2_nxt = pin_s2_r;
    if (ce) begin
      pin_s1_nxt = {pin14_n, pin22_n};
      pin_s2_nxt = pin_s1_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 2'h3;
      pin_s2_r <= 2'h3;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
    end
  end

  // Pin routing and thermal sensing
  logic thermal_en;
  logic p22_thermal;
  logic p14_thermal;
  logic thermal_now;

  assign thermal_en  = cfg3_r[`MCR_CFG3_THERMAL_BIT];
  assign p14_thermal = shared_pin_function == mcr_pkg::MCR_PIN_THERMAL;
  assign p22_thermal = thermal_en && !p14_thermal;
  assign thermal_now = (p22_thermal && !pin_s2_r[0]) || (p14_thermal && !pin_s2_r[1]);

  // Registered outputs
  logic       thermal_signal_r,  thermal_signal_nxt;
  logic       tstart_r, tstart_nxt;
  logic       max_cooling_on_thermal_r,  max_cooling_on_thermal_nxt;
  logic       p10o_r,   p10o_nxt;
  logic       p10oe_r,  p10oe_nxt;
  logic       p22m_r,   p22m_nxt;
  logic [1:0] p14_r,    p14_nxt;
  logic [3:0] cont_r,   cont_nxt;
  logic [3:0] strch_r,  strch_nxt;

  always_comb begin
    thermal_signal_nxt  = thermal_signal_r;
    tstart_nxt = tstart_r;
    max_cooling_on_thermal_nxt  = max_cooling_on_thermal_r;
    p10o_nxt   = p10o_r;
    p10oe_nxt  = p10oe_r;
    p22m_nxt   = p22m_r;
    p14_nxt    = p14_r;
    cont_nxt   = cont_r;
    strch_nxt  = strch_r;
    if (ce) begin
      thermal_signal_nxt  = thermal_now;
      tstart_nxt = thermal_now && !thermal_signal_r && thermal_timer_en;
      max_cooling_on_thermal_nxt  = thermal_now && thermal_is_input
                   && cfg3_r[`MCR_CFG3_MAX_COOLING_ON_THERMAL_BIT];
      p22m_nxt   = p22_thermal;
      p14_nxt    = shared_pin_function;
      if (cfg3_r[`MCR_CFG3_ALERT_BIT]) begin
        // Open-drain alert: pull low only while an alert is pending
        p10o_nxt  = 1'b0;
        p10oe_nxt = smbalert_req;
      end else begin
        p10o_nxt  = fan_drive_two_output;
        p10oe_nxt = 1'b1;
      end
      cont_nxt  = cfg3_r[`MCR_CFG3_CONT_LSB +: 4];
      // Every channel, one to four, relies on dc drive while continuous
      strch_nxt = ~cfg3_r[`MCR_CFG3_CONT_LSB +: 4];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      thermal_signal_r  <= 1'b0;
      tstart_r <= 1'b0;
      max_cooling_on_thermal_r  <= 1'b0;
      p10o_r   <= 1'b0;
      p10oe_r  <= 1'b0;
      p22m_r   <= 1'b0;
      p14_r    <= 2'h0;
      cont_r   <= 4'h0;
      strch_r  <= 4'hF;
    end else begin
      thermal_signal_r  <= thermal_signal_nxt;
      tstart_r <= tstart_nxt;
      max_cooling_on_thermal_r  <= max_cooling_on_thermal_nxt;
      p10o_r   <= p10o_nxt;
      p10oe_r  <= p10oe_nxt;
      p22m_r   <= p22m_nxt;
      p14_r    <= p14_nxt;
      cont_r   <= cont_nxt;
      strch_r  <= strch_nxt;
    end
  end

  assign thermal_asserted       = thermal_signal_r;
  assign thermal_timer_start    = tstart_r;
  assign max_cooling_on_thermal = max_cooling_on_thermal_r;
  assign pin10_o                = p10o_r;
  assign pin10_oe               = p10oe_r;
  assign pin22_thermal_mode     = p22m_r;
  assign pin14_role             = mcr_pkg::mcr_pin_fn_t'(p14_r);
  assign continuous_tach        = cont_r;
  assign pulse_stretch_en       = strch_r;

  mcr_tach_tick #(
    .SLOW_CYC (TACH_SLOW_CYC),
    .FAST_CYC (TACH_FAST_CYC)
  ) u_tick (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ce      (ce),
    .fast    (cfg3_r[`MCR_CFG3_FAST_BIT]),
    .tick    (tach_measure)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_ext_read;
    ce && rd_ext;
  endsequence

  sequence s_new_v12;
    ce && meas_valid && !frz_r[0];
  endsequence

  a_cfg_lock_hold: assert property (ce && wr_cfg3 && cfg_lock |=> $stable(cfg3_r))
    else $error("locked config register changed on write");

  a_ext_write_ignored: assert property (ce && reg_wr && reg_addr == `MCR_ADDR_EXT_LSBS
      && !meas_valid && !reg_rd && high_byte_rd == 4'h0 |=> $stable(ext_r) && $stable(frz_r))
    else $error("write altered LSB register or freeze");

  a_freeze_on_read: assert property (s_ext_read
      |=> frz_r == 4'hF && reg_rdata == $past(ext_r))
    else $error("LSB read did not freeze or return data");

  a_frozen_hold: assert property (ce && frz_r[3] && !rd_ext && !high_byte_rd[3]
      |=> ext_r[7:6] == $past(ext_r[7:6]) && frz_r[3])
    else $error("frozen channel updated");

  a_v12_capture: assert property (s_new_v12 |=> ext_r[1:0] == $past(v12_meas[1:0]))
    else $error("12 V low bits not captured");

  a_pin_alert_drive: assert property (ce && cfg3_r[0] && smbalert_req |=> pin10_oe && !pin10_o)
    else $error("alert not driven on shared pin");

  a_fan_two_drive: assert property (ce && !cfg3_r[0] |=> pin10_oe
      && pin10_o == $past(fan_drive_two_output))
    else $error("fan drive two not passed to shared pin");

  a_pin22_route: assert property (ce |=> pin22_thermal_mode
      == ($past(cfg3_r[1]) && $past(shared_pin_function) != 2'h1))
    else $error("pin 22 role wrong");

  a_max_cooling_on_thermal_full: assert property (ce && thermal_now && thermal_is_input && cfg3_r[2]
      |=> max_cooling_on_thermal)
    else $error("max_cooling_on_thermal did not force full cooling");

  a_timer_start: assert property (ce && thermal_now && !thermal_signal_r && thermal_timer_en
      |=> thermal_timer_start ##1 (!thermal_timer_start || !$past(ce)))
    else $error("thermal timer start not pulsed");

  a_stretch_off: assert property (ce |=> continuous_tach == $past(cfg3_r[7:4])
      && pulse_stretch_en == ~$past(cfg3_r[7:4]))
    else $error("pulse stretching not disabled with continuous tach");

endmodule // mcr_regs

// ---- hw/mcr_defines.svh ----
/*
  Register offsets, field positions, reset values and timing counts of the
  extended-resolution and pin/tach configuration register pair.
  Assumes a 125 MHz reference clock and an 8-bit register port from the
  serial management front end.
*/
`ifndef MCR_DEFINES_SVH
`define MCR_DEFINES_SVH

`define MCR_ADDR_EXT_LSBS      8'h77
`define MCR_ADDR_CFG3          8'h78
`define MCR_EXT_RESET          8'h00
`define MCR_CFG3_RESET         8'h00
`define MCR_RDATA_UNMAPPED     8'h00

`define MCR_EXT_V12_LSB        0
`define MCR_EXT_REM1_LSB       2
`define MCR_EXT_ONCHIP_LSB     4
`define MCR_EXT_REM2_LSB       6

`define MCR_CFG3_ALERT_BIT     0
`define MCR_CFG3_THERMAL_BIT   1
`define MCR_CFG3_MAX_COOLING_ON_THERMAL_BIT     2
`define MCR_CFG3_FAST_BIT      3
`define MCR_CFG3_CONT_LSB      4

`define MCR_CLK_KHZ            125000
`define MCR_TACH_SLOW_MS       1000
`define MCR_TACH_FAST_MS       250
`define MCR_TACH_SLOW_CYC      (`MCR_TACH_SLOW_MS * `MCR_CLK_KHZ)
`define MCR_TACH_FAST_CYC      (`MCR_TACH_FAST_MS * `MCR_CLK_KHZ)

`endif

// ---- hw/mcr_pkg.sv ----
/*
  Types shared by the register pair and its users.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mcr_pkg;

  // Role of the shared multi-function pin, as coded by the pin-function field
  typedef enum logic [1:0] {
    MCR_PIN_FAN_SPEED_FOUR = 2'h0,
    MCR_PIN_THERMAL        = 2'h1,
    MCR_PIN_SMBALERT       = 2'h2,
    MCR_PIN_GENERAL_IO_SIX = 2'h3
  } mcr_pin_fn_t;

endpackage

// ---- hw/mcr_tach_tick.sv ----
/*
  Tach measurement scheduler: one pulse per slow period, or per fast
  period while fast is high.
  Assumes ce freezes the count; fast comes from logic on the same clock.
*/
`include "mcr_defines.svh"

module mcr_tach_tick #(
  parameter int unsigned SLOW_CYC = `MCR_TACH_SLOW_CYC,
  parameter int unsigned FAST_CYC = `MCR_TACH_FAST_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic ce,
  // Control and event
  input  wire logic fast,
  output logic      tick
);

  localparam int unsigned CW = $clog2(SLOW_CYC + 1);

  generate
    if (FAST_CYC < 1 || FAST_CYC > SLOW_CYC) begin : g_bad_period
      $error("mcr_tach_tick: need 1 <= FAST_CYC <= SLOW_CYC");
    end
  endgenerate

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] term;
  logic          tick_r;
  logic          tick_nxt;

  always_comb begin
    term     = fast ? CW'(FAST_CYC - 1) : CW'(SLOW_CYC - 1);
    cnt_nxt  = cnt_r;
    tick_nxt = tick_r;
    if (ce) begin
      // A switch to the fast rate past its end fires at once
      if (cnt_r >= term) begin
        cnt_nxt  = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt  = cnt_r + CW'(1);
        tick_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_tach_rate_end: assert property (ce && cnt_r == term |=> tick_r && cnt_r == '0)
    else $error("tach pulse missing at end of period");

endmodule // mcr_tach_tick

// ---- tb/mcr_host.sv ----
/*
  Register host model: single-byte writes and reads on the register port.
  Assumes the port takes a strobe at a rising edge and answers one edge later.
*/
module mcr_host (
  // Clock
  input  wire logic       ref_clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // Released data is inverted so a stale byte is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = dat;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~dat;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    dat    = reg_rdata;
  endtask
endmodule // mcr_host

// ---- tb/mcr_regs_tb.sv ----
/*
  Self-checking bench of the register pair with shortened tach periods.
  Assumes the host model drives the register port; inputs change at negedge.
*/
module mcr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOW = 40;
  localparam int FAST = 10;

  logic                 ref_clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 ce = 1'b1;
  logic [7:0]           reg_addr, reg_wdata, reg_rdata, d;
  logic                 reg_wr, reg_rd, cfg_lock, thermal_is_input, thermal_timer_en;
  logic                 meas_valid, pin22_n, pin14_n, pin22_thermal_mode;
  logic                 thermal_asserted, thermal_timer_start, smbalert_req;
  logic                 fan_drive_two_output, pin10_o, pin10_oe;
  logic                 max_cooling_on_thermal, tach_measure;
  logic [1:0]           shared_pin_function;
  logic [9:0]           v12, rem1, onc, rem2;
  logic [3:0]           high_byte_rd, high_byte_freeze, continuous_tach, pulse_stretch_en;
  mcr_pkg::mcr_pin_fn_t pin14_role;
  int                   n_fail = 0;
  int                   n_tests = 0;

  always #4 ref_clk = ~ref_clk;

  mcr_host u_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  mcr_regs #(.TACH_SLOW_CYC(SLOW), .TACH_FAST_CYC(FAST)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_lock(cfg_lock),
    .shared_pin_function(shared_pin_function), .thermal_is_input(thermal_is_input),
    .thermal_timer_en(thermal_timer_en), .meas_valid(meas_valid), .v12_meas(v12),
    .remote_one_meas(rem1), .onchip_meas(onc), .remote_two_meas(rem2),
    .high_byte_rd(high_byte_rd), .high_byte_freeze(high_byte_freeze), .pin22_n(pin22_n),
    .pin14_n(pin14_n), .pin22_thermal_mode(pin22_thermal_mode), .pin14_role(pin14_role),
    .thermal_asserted(thermal_asserted), .thermal_timer_start(thermal_timer_start),
    .smbalert_req(smbalert_req), .fan_drive_two_output(fan_drive_two_output),
    .pin10_o(pin10_o), .pin10_oe(pin10_oe), .max_cooling_on_thermal(max_cooling_on_thermal),
    .tach_measure(tach_measure), .continuous_tach(continuous_tach),
    .pulse_stretch_en(pulse_stretch_en));

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic meas(input logic [9:0] a, b, c, e);
    @(negedge ref_clk);
    {v12, rem1, onc, rem2} = {a, b, c, e};
    meas_valid = 1'b1;
    cyc(1);
    meas_valid = 1'b0;
  endtask

  task automatic hb_release;
    @(negedge ref_clk);
    high_byte_rd = 4'hF;
    cyc(1);
    high_byte_rd = 4'h0;
    cyc(1);
    chk(8'(high_byte_freeze), 8'h00);
  endtask

  // Gap in cycles between two tach pulses
  task automatic gap(output int n);
    int k;
    k = 0;
    while (tach_measure !== 1'b1) begin
      cyc(1);
      k++;
      if (k > 200) begin
        n_fail++;
        $display("ERROR t=%0t got %h exp %h", $time, k, 1);
        test_done();
      end
    end
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (tach_measure !== 1'b1 && n < 200);
  endtask

  task automatic t_reset;
    u_host.rd(8'h77, d);
    chk(d, 8'h00);
    u_host.rd(8'h78, d);
    chk(d, 8'h00);
    u_host.rd(8'h79, d);
    chk(d, 8'h00);
    chk(8'(pulse_stretch_en), 8'h0F);
    chk(8'(pin10_oe), 8'h01);
    hb_release();
    $display("t_reset done");
  endtask

  task automatic t_ext;
    meas(10'h3F1, 10'h2A2, 10'h1B3, 10'h0C0);
    u_host.rd(8'h77, d);
    chk(d, 8'h39);
    chk(8'(high_byte_freeze), 8'h0F);
    meas(10'h002, 10'h003, 10'h000, 10'h001);
    u_host.wr(8'h77, 8'hFF);
    u_host.rd(8'h77, d);
    chk(d, 8'h39);
    hb_release();
    meas(10'h002, 10'h003, 10'h000, 10'h001);
    u_host.rd(8'h77, d);
    chk(d, 8'h4E);
    @(negedge ref_clk);
    high_byte_rd = 4'h1;
    cyc(1);
    high_byte_rd = 4'h0;
    chk(8'(high_byte_freeze), 8'h0E);
    meas(10'h003, 10'h000, 10'h003, 10'h002);
    u_host.rd(8'h77, d);
    chk(d, 8'h4F);
    hb_release();
    $display("t_ext done");
  endtask

  task automatic t_alert;
    smbalert_req = 1'b1;
    u_host.wr(8'h78, 8'h01);
    cyc(2);
    chk({6'h00, pin10_oe, pin10_o}, 8'h02);
    smbalert_req = 1'b0;
    cyc(2);
    chk(8'(pin10_oe), 8'h00);
    fan_drive_two_output = 1'b1;
    u_host.wr(8'h78, 8'hF0);
    cyc(2);
    chk({6'h00, pin10_oe, pin10_o}, 8'h03);
    chk(8'(continuous_tach), 8'h0F);
    chk(8'(pulse_stretch_en), 8'h00);
    u_host.rd(8'h78, d);
    chk(d, 8'hF0);
    u_host.wr(8'h78, 8'h50);
    cyc(2);
    chk(8'(pulse_stretch_en), 8'h0A);
    $display("t_alert done");
  endtask

  task automatic t_pins;
    for (int b = 0; b < 2; b++) begin
      for (int f = 0; f < 4; f++) begin
        shared_pin_function = 2'(f);
        u_host.wr(8'h78, {6'h00, 1'(b), 1'b0});
        cyc(2);
        chk(8'(pin22_thermal_mode), 8'((b == 1) && (f != 1)));
        chk(8'(pin14_role), 8'(f));
      end
    end
    shared_pin_function = 2'h0;
    $display("t_pins done");
  endtask

  task automatic t_max_cooling_on_thermal;
    int k;
    k = 0;
    thermal_is_input = 1'b1;
    thermal_timer_en = 1'b1;
    u_host.wr(8'h78, 8'h06);
    cyc(2);
    pin22_n = 1'b0;
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      if (thermal_timer_start === 1'b1)
        k++;
    end
    chk(8'(k), 8'h01);
    chk(8'(thermal_asserted), 8'h01);
    chk(8'(max_cooling_on_thermal), 8'h01);
    thermal_is_input = 1'b0;
    cyc(2);
    chk(8'(max_cooling_on_thermal), 8'h00);
    thermal_is_input = 1'b1;
    u_host.wr(8'h78, 8'h02);
    cyc(2);
    chk(8'(max_cooling_on_thermal), 8'h00);
    shared_pin_function = 2'h1;
    cyc(4);
    chk(8'(thermal_asserted), 8'h00);
    pin14_n = 1'b0;
    cyc(4);
    chk(8'(thermal_asserted), 8'h01);
    {pin14_n, pin22_n} = 2'b11;
    shared_pin_function = 2'h0;
    cyc(4);
    $display("t_max_cooling_on_thermal done");
  endtask

  task automatic t_tach;
    int n;
    u_host.wr(8'h78, 8'h00);
    gap(n);
    chk(8'(n), 8'(SLOW));
    u_host.wr(8'h78, 8'h08);
    gap(n);
    chk(8'(n), 8'(FAST));
    $display("t_tach done");
  endtask

  task automatic t_lock;
    u_host.wr(8'h78, 8'hA5);
    cfg_lock = 1'b1;
    u_host.wr(8'h78, 8'h3C);
    u_host.rd(8'h78, d);
    chk(d, 8'hA5);
    cfg_lock = 1'b0;
    u_host.wr(8'h78, 8'h3C);
    u_host.rd(8'h78, d);
    chk(d, 8'h3C);
    $display("t_lock done");
  endtask

  initial begin
    {cfg_lock, thermal_is_input, thermal_timer_en, meas_valid} = 4'h0;
    {smbalert_req, fan_drive_two_output} = 2'b00;
    {pin22_n, pin14_n} = 2'b11;
    shared_pin_function = 2'h0;
    {v12, rem1, onc, rem2} = 40'h0;
    high_byte_rd = 4'h0;
    repeat (6) @(negedge ref_clk);
    rstn = 1'b1;
    t_reset();
    t_ext();
    t_alert();
    t_pins();
    t_max_cooling_on_thermal();
    t_tach();
    t_lock();
    test_done();
  end

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("ERROR t=%0t got %h exp %h", $time, 1, 0);
    test_done();
  end
endmodule // mcr_regs_tb
